// file: tb/tb_top.sv
// tb_top: directed checks of the scroll area block.
// assumes the host model drives settings; the bench drives scanRow.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vsa_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  vsa_row_t scanRow = 6'h00;
  logic areaWrite, scrollStep, settingsBad;
  vsa_row_t areaFixed, startLine, memRow, fixedRows, scrollOffset;
  vsa_cnt_t areaScroll, activeRowCount, scrollRows;
  vsa_region_e rowRegion;
  int n_mismatch = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  vsa_host_model host (.clk(clk), .areaWrite(areaWrite),
    .areaFixed(areaFixed), .areaScroll(areaScroll),
    .startLine(startLine), .activeRowCount(activeRowCount),
    .scrollStep(scrollStep));
  vsa_ctrl dut (.clk(clk), .sys_rst(sys_rst), .areaWrite(areaWrite),
    .areaFixed(areaFixed), .areaScroll(areaScroll),
    .startLine(startLine), .activeRowCount(activeRowCount),
    .scrollStep(scrollStep), .scanRow(scanRow), .memRow(memRow),
    .rowRegion(rowRegion), .fixedRows(fixedRows),
    .scrollRows(scrollRows), .scrollOffset(scrollOffset),
    .settingsBad(settingsBad));
  // ----------------------------------------------------------------
  // compare and lookup tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [6:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // memRow answers for the scanRow of the previous cycle
  task automatic look(input vsa_row_t s, e, input logic [2:0] r);
    @(posedge clk) #1;
    scanRow = s;
    @(posedge clk) #1;
    chk("memRow", {1'b0, e}, {1'b0, memRow});
    chk("rowRegion", {4'h0, r}, {4'h0, rowRegion});
  endtask : look
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk("fixedRows", 7'h00, {1'b0, fixedRows});
    chk("scrollRows", 7'h40, scrollRows);
    $display("test reset done");
    host.step();
    chk("scrollOffset", 7'h01, {1'b0, scrollOffset});
    look(6'h3f, 6'h3e, VSA_RG_SCROLL);
    look(6'h00, 6'h3f, VSA_RG_SCROLL);
    $display("test whole panel done");
    host.set_area(6'h08, 7'h30);
    chk("fixedRows", 7'h08, {1'b0, fixedRows});
    chk("scrollRows", 7'h30, scrollRows);
    host.step();
    look(6'h08, 6'h37, VSA_RG_SCROLL);
    look(6'h07, 6'h07, VSA_RG_TOP);
    look(6'h37, 6'h36, VSA_RG_SCROLL);
    look(6'h38, 6'h38, VSA_RG_BOTTOM);
    $display("test middle band done");
    host.set_area(6'h10, 7'h30);
    host.step();
    look(6'h3f, 6'h3e, VSA_RG_SCROLL);
    look(6'h0f, 6'h0f, VSA_RG_TOP);
    $display("test lower band done");
    host.set_area(6'h08, 7'h40);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h01, {6'h00, settingsBad});
    host.set_area(6'h00, 7'h41);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h01, {6'h00, settingsBad});
    host.set_area(6'h00, 7'h40);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h00, {6'h00, settingsBad});
    host.set_area(6'h00, 7'h10);
    host.set_start(6'h10);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h01, {6'h00, settingsBad});
    host.set_start(6'h0f);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h00, {6'h00, settingsBad});
    host.set_rows(7'h0f);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h01, {6'h00, settingsBad});
    host.set_rows(7'h40);
    host.set_start(6'h00);
    host.set_area(6'h00, 7'h00);
    repeat (2) @(posedge clk);
    #1 chk("settingsBad", 7'h01, {6'h00, settingsBad});
    $display("test limits done");
    host.set_area(6'h3e, 7'h02);
    host.step();
    look(6'h3e, 6'h3f, VSA_RG_SCROLL);
    look(6'h3f, 6'h3e, VSA_RG_SCROLL);
    host.step();
    chk("scrollOffset", 7'h00, {1'b0, scrollOffset});
    $display("test wrap done");
    @(posedge clk) #1 sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk("fixedRows", 7'h00, {1'b0, fixedRows});
    chk("scrollRows", 7'h40, scrollRows);
    $display("test second reset done");
    final_report();
  end
endmodule : tb_top

// file: tb/vsa_host_model.sv
// vsa_host_model: host that sends scroll area settings.
// assumes the bench calls its tasks; inputs move 1 ns after clk.
module vsa_host_model
  import vsa_pkg::*;
(
  // clock
  input wire logic clk,
  // area command parameters
  output logic areaWrite,
  output vsa_row_t areaFixed,
  output vsa_cnt_t areaScroll,
  // settings the area is checked against
  output vsa_row_t startLine,
  output vsa_cnt_t activeRowCount,
  // scroll stepping
  output logic scrollStep
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    areaWrite = 1'b0;
    scrollStep = 1'b0;
    areaFixed = 6'h00;
    areaScroll = 7'h40;
    startLine = 6'h00;
    activeRowCount = 7'h40;
  end
  // illegal sums only when a test asks for them
  task automatic set_area(input vsa_row_t f, input vsa_cnt_t s);
    @(posedge clk) #1;
    areaWrite = 1'b1;
    areaFixed = f;
    areaScroll = s;
    @(posedge clk) #1;
    areaWrite = 1'b0;
  endtask : set_area
  // single steps keep the offset below the scroll count
  task automatic step();
    @(posedge clk) #1;
    scrollStep = 1'b1;
    @(posedge clk) #1;
    scrollStep = 1'b0;
  endtask : step
  // start line may break the limit when a test wants the flag
  task automatic set_start(input vsa_row_t l);
    @(posedge clk) #1;
    startLine = l;
  endtask : set_start
  task automatic set_rows(input vsa_cnt_t m);
    @(posedge clk) #1;
    activeRowCount = m;
  endtask : set_rows
endmodule : vsa_host_model

// file: verilog/vsa_ctrl.sv
// vsa_ctrl: holds the vertical scroll area settings and steps the scroll.
// assumes the host keeps the settings legal; violations are only flagged.
// What this block does
// - six-bit top fixed count, resets to zero
// - seven-bit count of scrolling rows
// - scroll region starts after fixed rows
// - scrolling count resets to 64
// - last scroll row wraps to first
// - zero fixed, 64 scroll: whole panel scrolls
// - nonzero fixed, total under 64: middle band scrolls
// - total 64: lower band scrolls
module vsa_ctrl
  import vsa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // settings write from command decoder
  input wire logic areaWrite,
  input wire vsa_row_t areaFixed,
  input wire vsa_cnt_t areaScroll,
  input wire vsa_row_t startLine,
  input wire vsa_cnt_t activeRowCount,
  // scroll stepping
  input wire logic scrollStep,
  // row scan
  input wire vsa_row_t scanRow,
  output vsa_row_t memRow,
  output vsa_region_e rowRegion,
  // status
  output vsa_row_t fixedRows,
  output vsa_cnt_t scrollRows,
  output vsa_row_t scrollOffset,
  output logic settingsBad
);
  vsa_row_t fixed_reg, fixed_next;
  vsa_cnt_t scroll_reg, scroll_next;
  vsa_row_t offs_reg, offs_next;
  vsa_row_t mem_reg, mem_next;
  vsa_region_e reg_reg, reg_next;
  logic bad_reg, bad_next;
  vsa_row_t mapRow;
  vsa_region_e mapRegion;

  // ----------------------------------------------------------------
  // legality check of host settings
  // ----------------------------------------------------------------
  // one flag for all four host limits; which one broke is not kept
  function automatic logic vsa_bad(vsa_row_t f, vsa_cnt_t s, vsa_row_t o,
                                   vsa_row_t l, vsa_cnt_t m);
    vsa_bad = (8'(f) + 8'(s) > 8'(m))
           || (s > m)
           || (7'(o) >= s)
           || (7'(l) >= s);
  endfunction : vsa_bad

  vsa_row_map u_map (
    .fixedRows(fixed_reg),
    .scrollRows(scroll_reg),
    .scrollOffset(offs_reg),
    .scanRow(scanRow),
    .memRow(mapRow),
    .region(mapRegion)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    fixed_next = fixed_reg;
    scroll_next = scroll_reg;
    offs_next = offs_reg;
    // a new area restarts from the unshifted picture, so an old offset
    // can never point past the end of a smaller region
    if (areaWrite)
    begin
      fixed_next = areaFixed;
      scroll_next = areaScroll;
      offs_next = '0;
    end
    // an empty region has nothing to step, so the step is dropped
    else if (scrollStep && scroll_reg != '0)
    begin
      // offset stays below count so the region wraps cleanly
      if (7'(offs_reg) + 7'h01 >= scroll_reg)
      begin
        offs_next = '0;
      end
      else
      begin
        offs_next = 6'(offs_reg + 6'h01);
      end
    end
    mem_next = mapRow;
    reg_next = mapRegion;
    // flag lags the settings by one cycle; it only reports, never blocks
    bad_next = vsa_bad(fixed_reg, scroll_reg, offs_reg, startLine,
                       activeRowCount);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fixed_reg <= VSA_FIXED_RST;
      scroll_reg <= VSA_SCROLL_RST;
      offs_reg <= '0;
      mem_reg <= '0;
      reg_reg <= VSA_RG_TOP;
      bad_reg <= 1'b0;
    end
    else
    begin
      fixed_reg <= fixed_next;
      scroll_reg <= scroll_next;
      offs_reg <= offs_next;
      mem_reg <= mem_next;
      reg_reg <= reg_next;
      bad_reg <= bad_next;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // status ports are the state registers themselves
  assign fixedRows = fixed_reg;
  assign scrollRows = scroll_reg;
  assign scrollOffset = offs_reg;
  assign memRow = mem_reg;
  assign rowRegion = reg_reg;
  assign settingsBad = bad_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fixed_reset: assert property ($past(sys_rst) |->
      fixed_reg == 6'h00)
    else $error("fixed count not zero after reset");
  a_scroll_reset: assert property ($past(sys_rst) |->
      scroll_reg == 7'h40)
    else $error("scroll count not 64 after reset");
  a_area_load: assert property (areaWrite |=>
      fixed_reg == $past(areaFixed) && scroll_reg == $past(areaScroll))
    else $error("area settings not loaded");
  a_area_hold: assert property (!areaWrite |=>
      fixed_reg == $past(fixed_reg) && scroll_reg == $past(scroll_reg))
    else $error("area settings changed without a write");
  a_offset_wrap: assert property (!areaWrite && scrollStep
      && 7'(offs_reg) + 7'h01 == scroll_reg |=> offs_reg == 6'h00)
    else $error("offset did not wrap to first row");
  a_offset_step: assert property (!areaWrite && scrollStep
      && 7'(offs_reg) + 7'h01 < scroll_reg
      |=> offs_reg == $past(offs_reg) + 6'h01)
    else $error("offset did not advance by one");
  a_offset_idle: assert property (!areaWrite && (!scrollStep
      || scroll_reg == 7'h00) |=> offs_reg == $past(offs_reg))
    else $error("offset moved without a step");
  a_top_fixed: assert property (8'(scanRow) < 8'(fixed_reg)
      |=> memRow == $past(scanRow) && rowRegion == VSA_RG_TOP)
    else $error("fixed row displaced");
  a_region_start: assert property (scanRow == fixed_reg
      && scroll_reg != 7'h00 && offs_reg == 6'h00
      |=> rowRegion == VSA_RG_SCROLL && memRow == $past(scanRow))
    else $error("region not at first row below fixed area");
  a_wrap_first: assert property (scanRow == fixed_reg
      && scroll_reg > 7'h01 && offs_reg == 6'h01
      |=> memRow == 6'(7'($past(fixed_reg)) + $past(scroll_reg) - 7'h01))
    else $error("last region row not shown on first");
  a_bottom_still: assert property (8'(scanRow) >= 8'(fixed_reg)
      + 8'(scroll_reg) |=> memRow == $past(scanRow)
      && rowRegion == VSA_RG_BOTTOM)
    else $error("row below region displaced");
  a_middle_band: assert property (fixed_reg != 6'h00
      && 8'(fixed_reg) + 8'(scroll_reg) < 8'h40 && scroll_reg != 7'h00
      && scanRow == fixed_reg |=> rowRegion == VSA_RG_SCROLL)
    else $error("middle band not scrolling");
  a_whole_panel: assert property (fixed_reg == 6'h00
      && scroll_reg == 7'h40 |=> rowRegion == VSA_RG_SCROLL)
    else $error("whole panel not scrolling");
  a_lower_band: assert property (fixed_reg != 6'h00
      && 8'(fixed_reg) + 8'(scroll_reg) == 8'h40 && scanRow == 6'h3f
      |=> rowRegion == VSA_RG_SCROLL)
    else $error("lower band misses last row");

  // ----------------------------------------------------------------
  // legality flag
  // ----------------------------------------------------------------
  a_area_flag: assert property (8'(fixed_reg) + 8'(scroll_reg)
      > 8'(activeRowCount) |=> settingsBad)
    else $error("oversize area not flagged");
  a_bad_flag: assert property (scroll_reg > activeRowCount
      |=> settingsBad)
    else $error("oversize scroll count not flagged");
  a_offset_flag: assert property (7'(offs_reg) >= scroll_reg
      |=> settingsBad)
    else $error("offset violation not flagged");
  a_bad_start: assert property (7'(startLine) >= scroll_reg
      |=> settingsBad)
    else $error("start line violation not flagged");
  a_bad_clear: assert property (scroll_reg <= activeRowCount
      && 8'(fixed_reg) + 8'(scroll_reg) <= 8'(activeRowCount)
      && 7'(offs_reg) < scroll_reg && 7'(startLine) < scroll_reg
      |=> !settingsBad)
    else $error("legal settings flagged");

  // ----------------------------------------------------------------
  // scenarios worth seeing
  // ----------------------------------------------------------------
  c_area_write: cover property (areaWrite);
  c_wrap: cover property (scrollStep && offs_reg != 6'h00
      ##1 offs_reg == 6'h00);
  c_bottom: cover property (rowRegion == VSA_RG_BOTTOM);
  c_bad: cover property (settingsBad);
  c_last_row: cover property (rowRegion == VSA_RG_SCROLL && memRow == 6'h3f);
endmodule : vsa_ctrl

// file: verilog/vsa_pkg.sv
// vsa_pkg: constants shared by the vertical scroll area block.
// assumes one 40 MHz clock and a synchronous active-high reset.
package vsa_pkg;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int VSA_ROW_W = 6;
  localparam int VSA_CNT_W = 7;
  localparam logic [5:0] VSA_FIXED_RST = 6'h00;
  localparam logic [6:0] VSA_SCROLL_RST = 7'h40;
  localparam logic [6:0] VSA_PANEL_ROWS = 7'h40;
  typedef logic [5:0] vsa_row_t;
  typedef logic [6:0] vsa_cnt_t;
  // ----------------------------------------------------------------
  // region classes of a scanned row
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    VSA_RG_TOP = 3'b001,
    VSA_RG_SCROLL = 3'b010,
    VSA_RG_BOTTOM = 3'b100
  } vsa_region_e;
endpackage : vsa_pkg

// file: verilog/vsa_row_map.sv
// vsa_row_map: maps a scanned row to the memory row that it shows.
// assumes settings are stable while the row is looked up.
module vsa_row_map
  import vsa_pkg::*;
(
  // settings
  input wire vsa_row_t fixedRows,
  input wire vsa_cnt_t scrollRows,
  input wire vsa_row_t scrollOffset,
  // lookup
  input wire vsa_row_t scanRow,
  output vsa_row_t memRow,
  output vsa_region_e region
);
  logic [7:0] topEnd;
  logic [7:0] rel;
  logic [7:0] sum;
  always_comb
  begin
    topEnd = 8'(fixedRows) + 8'(scrollRows);
    rel = 8'(scanRow) - 8'(fixedRows);
    // content moves down a row per step: the last region row reaches
    // the first one, hence the offset is taken away
    sum = rel + 8'(scrollRows) - 8'(scrollOffset);
    memRow = scanRow;
    if (8'(scanRow) < 8'(fixedRows))
    begin
      region = VSA_RG_TOP;
    end
    else if (8'(scanRow) < topEnd)
    begin
      // region starts right after the fixed rows
      region = VSA_RG_SCROLL;
      // wrap inside the region: last scroll row follows into first
      if (sum >= 8'(scrollRows))
      begin
        sum = sum - 8'(scrollRows);
      end
      memRow = 6'(sum + 8'(fixedRows));
    end
    else
    begin
      region = VSA_RG_BOTTOM;
    end
  end
endmodule : vsa_row_map
